//--- verilog/sequential_ram_access_port.sv
// What this block does
// - with idle check enabled, buffer init is accepted only while line idle
// - with idle check disabled, buffer init is accepted regardless of line
// - timeout select 00/01/10/11 gives 420/105/52.5/26.25 ms periods
// - low pointer write loads pointer and prefetches the addressed byte
// - buffer bytes pass through the 8-bit data port register
// - auto-increment advances pointer after each access and prefetches after each data read
// - data reads come from a prefetched register, never stalled
// - write data is held in a 16-entry write queue, committed later
// - setup bit 0 halves the buffer arbitration rate
// - 2048 by 8 buffer reachable only through pointer and data port
// - host may read back the pointer after a burst
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "ram_port_defs.svh"

module sequential_ram_access_port #(
  parameter int unsigned RECON_CYC_0 = `RECON_T0_US * `CLK_MHZ,
  parameter int unsigned RECON_CYC_1 = `RECON_T1_US * `CLK_MHZ,
  parameter int unsigned RECON_CYC_2 = `RECON_T2_US * `CLK_MHZ,
  parameter int unsigned RECON_CYC_3 = `RECON_T3_US * `CLK_MHZ
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // network side
  input  wire logic        line_idle,
  input  wire logic        reconfig_restart,
  output logic             reconfig_timeout
);
  ram_port_pkg::init_state_t init_state;
  ram_port_pkg::init_state_t next_init_state;

  logic                  dp_act;
  logic                  dp_write;
  logic [7:0]            dp_idx;
  logic [2:0]            hi_bits;
  logic                  autoinc;
  logic [`BUF_AW-1:0]    ptr;
  logic [7:0]            data_reg;
  logic                  slow_arb;
  logic                  idle_dis;
  logic [1:0]            tmo_sel;
  logic                  pf_pending;
  logic                  pf_capture;
  logic                  arb_phase;
  logic [`BUF_AW-1:0]    init_addr;
  logic                  init_refused;
  logic                  next_dp_act;
  logic                  next_dp_write;
  logic [7:0]            next_dp_idx;
  logic [2:0]            next_hi_bits;
  logic                  next_autoinc;
  logic [`BUF_AW-1:0]    next_ptr;
  logic [7:0]            next_data_reg;
  logic                  next_slow_arb;
  logic                  next_idle_dis;
  logic [1:0]            next_tmo_sel;
  logic                  next_pf_pending;
  logic [`BUF_AW-1:0]    next_init_addr;
  logic                  next_init_refused;
  logic [31:0]           next_hrdata;
  logic [7:0]            wd;
  logic [7:0]            ap_idx;
  logic [7:0]            rd_byte;
  logic                  ap_take;
  logic                  ap_read_data;
  logic                  wr_fire;
  logic                  arb_tick;
  logic                  init_busy;
  logic                  pf_go;
  logic                  fifo_in_valid;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic                  fifo_out_ready;
  logic [`FIFO_W-1:0]    fifo_out_data;
  logic                  ram_we;
  logic [`BUF_AW-1:0]    ram_addr;
  logic [`BUF_DW-1:0]    ram_wdata;
  logic [`BUF_DW-1:0]    ram_rdata;
  logic [`RECON_CW-1:0]  recon_cnt;
  logic [`RECON_CW-1:0]  next_recon_cnt;
  logic [`RECON_CW-1:0]  recon_last;
  logic                  next_reconfig_timeout;

  // bus decode
  assign wd           = hwdata[7:0];
  assign ap_idx       = haddr[`IDX_MSB:`IDX_LSB];
  assign ap_take      = hsel && htrans[`HTRANS_ACTIVE] && hready;
  assign ap_read_data = ap_take && !hwrite && (ap_idx == `IDX_DATA);
  assign fifo_in_valid = dp_act && dp_write && (dp_idx == `IDX_DATA);
  // a full write queue is the only thing that stalls the host
  assign hreadyout    = !(fifo_in_valid && !fifo_in_ready);
  assign wr_fire      = dp_act && dp_write && hreadyout;
  assign hresp        = 1'b0;

  // buffer arbitration: every cycle, or every other cycle when slowed
  assign arb_tick       = slow_arb ? arb_phase : 1'b1;
  assign init_busy      = (init_state == ram_port_pkg::INIT_CLEAR);
  // queued writes drain before a prefetch so reads see them
  assign fifo_out_ready = arb_tick && !init_busy;
  assign pf_go = pf_pending && !fifo_out_valid && arb_tick && !init_busy;

  always_comb begin
    ram_we    = fifo_out_valid && fifo_out_ready;
    ram_addr  = fifo_out_valid ? fifo_out_data[`FIFO_W-1:`BUF_DW] : ptr;
    ram_wdata = fifo_out_data[`BUF_DW-1:0];
    if (init_busy) begin
      ram_we    = arb_tick;
      ram_addr  = init_addr;
      ram_wdata = `RST_BYTE;
    end
  end

  always_comb begin
    case (ap_idx)
      `IDX_PTR_HIGH:   rd_byte = {autoinc, 4'h0, ptr[10:8]};
      `IDX_PTR_LOW:    rd_byte = ptr[7:0];
      // a prefetch landing this cycle is served straight from the buffer
      `IDX_DATA:       rd_byte = pf_capture ? ram_rdata : data_reg;
      `IDX_FIRST_SETUP_REGISTER:     rd_byte = {7'h00, slow_arb};
      `IDX_NET_TIMING: rd_byte = {5'h00, idle_dis, tmo_sel};
      `IDX_STATUS:     rd_byte = {3'h0, line_idle, !fifo_in_ready,
                                  pf_pending, init_refused, init_busy};
      default:         rd_byte = `RST_BYTE;
    endcase
  end

  always_comb begin
    next_dp_act       = dp_act;
    next_dp_write     = dp_write;
    next_dp_idx       = dp_idx;
    next_hi_bits      = hi_bits;
    next_autoinc      = autoinc;
    next_ptr          = ptr;
    next_data_reg     = data_reg;
    next_slow_arb     = slow_arb;
    next_idle_dis     = idle_dis;
    next_tmo_sel      = tmo_sel;
    next_pf_pending   = pf_pending;
    next_init_state   = init_state;
    next_init_addr    = init_addr;
    next_init_refused = init_refused;
    next_hrdata       = hrdata;
    if (hready) begin
      next_dp_act   = ap_take;
      next_dp_write = hwrite;
      next_dp_idx   = ap_idx;
    end
    if (pf_go) begin
      next_pf_pending = 1'b0;
    end
    if (pf_capture) begin
      next_data_reg = ram_rdata;
    end
    case (init_state)
      ram_port_pkg::INIT_IDLE: begin
      end
      ram_port_pkg::INIT_CLEAR: begin
        if (arb_tick) begin
          if (init_addr == `BUF_LAST) begin
            next_init_state = ram_port_pkg::INIT_IDLE;
          end else begin
            next_init_addr = init_addr + `PTR_STEP;
          end
        end
      end
      default: begin
        next_init_state = ram_port_pkg::INIT_IDLE;
      end
    endcase
    if (wr_fire) begin
      case (dp_idx)
        `IDX_PTR_HIGH: begin
          next_autoinc = wd[`PH_AUTOINC];
          next_hi_bits = wd[`PH_HI_MSB:0];
        end
        `IDX_PTR_LOW: begin
          next_ptr        = {hi_bits, wd};
          next_pf_pending = 1'b1;
        end
        `IDX_DATA: begin
          next_data_reg = wd;
          if (autoinc) begin
            next_ptr = ptr + `PTR_STEP;
          end
        end
        `IDX_FIRST_SETUP_REGISTER: begin
          next_slow_arb = wd[`SETUP_SLOW_ARB];
        end
        `IDX_NET_TIMING: begin
          next_idle_dis = wd[`NT_IDLE_DIS];
          next_tmo_sel  = wd[`NT_TMO_MSB:0];
        end
        `IDX_CTRL: begin
          if (wd[`CTRL_INIT] && !init_busy) begin
            if (line_idle || idle_dis) begin
              next_init_state = ram_port_pkg::INIT_CLEAR;
              next_init_addr  = `RST_PTR;
            end else begin
              next_init_refused = 1'b1;
            end
          end
        end
        `IDX_STATUS: begin
          if (wd[`ST_INIT_REFUSED]) begin
            next_init_refused = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (ap_take && !hwrite) begin
      next_hrdata = {`RD_PAD, rd_byte};
    end
    if (ap_read_data && autoinc) begin
      next_ptr        = next_ptr + `PTR_STEP;
      next_pf_pending = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dp_act       <= `RST_BIT;
      dp_write     <= `RST_BIT;
      dp_idx       <= `RST_BYTE;
      hi_bits      <= `RST_HI;
      autoinc      <= `RST_BIT;
      ptr          <= `RST_PTR;
      data_reg     <= `RST_BYTE;
      slow_arb     <= `RST_BIT;
      idle_dis     <= `RST_BIT;
      tmo_sel      <= `RST_TMO;
      pf_pending   <= `RST_BIT;
      pf_capture   <= `RST_BIT;
      arb_phase    <= `RST_BIT;
      init_state   <= ram_port_pkg::INIT_IDLE;
      init_addr    <= `RST_PTR;
      init_refused <= `RST_BIT;
      hrdata       <= `RST_WORD;
    end else begin
      dp_act       <= next_dp_act;
      dp_write     <= next_dp_write;
      dp_idx       <= next_dp_idx;
      hi_bits      <= next_hi_bits;
      autoinc      <= next_autoinc;
      ptr          <= next_ptr;
      data_reg     <= next_data_reg;
      slow_arb     <= next_slow_arb;
      idle_dis     <= next_idle_dis;
      tmo_sel      <= next_tmo_sel;
      pf_pending   <= next_pf_pending;
      pf_capture   <= pf_go;
      arb_phase    <= !arb_phase;
      init_state   <= next_init_state;
      init_addr    <= next_init_addr;
      init_refused <= next_init_refused;
      hrdata       <= next_hrdata;
    end
  end

  // reconfiguration timer
  always_comb begin
    case (tmo_sel)
      2'h0:    recon_last = `RECON_CW'(RECON_CYC_0 - 1);
      2'h1:    recon_last = `RECON_CW'(RECON_CYC_1 - 1);
      2'h2:    recon_last = `RECON_CW'(RECON_CYC_2 - 1);
      default: recon_last = `RECON_CW'(RECON_CYC_3 - 1);
    endcase
    next_recon_cnt        = recon_cnt + 1'b1;
    next_reconfig_timeout = 1'b0;
    if (reconfig_restart) begin
      next_recon_cnt = `RST_CNT;
    end else if (recon_cnt >= recon_last) begin
      next_recon_cnt        = `RST_CNT;
      next_reconfig_timeout = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      recon_cnt        <= `RST_CNT;
      reconfig_timeout <= `RST_BIT;
    end else begin
      recon_cnt        <= next_recon_cnt;
      reconfig_timeout <= next_reconfig_timeout;
    end
  end

  sync_fifo #(
    .WIDTH (`FIFO_W),
    .DEPTH (`FIFO_DEPTH)
  ) write_queue (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({ptr, wd}),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // buffer is internal only; the bus never maps it directly
  byte_ram #(
    .AW    (`BUF_AW),
    .DW    (`BUF_DW),
    .DEPTH (`BUF_DEPTH)
  ) buffer_store (
    .ref_clk (ref_clk),
    .we      (ram_we),
    .addr    (ram_addr),
    .wdata   (ram_wdata),
    .rdata   (ram_rdata)
  );

  chk_init_refuse: assert property (@(posedge ref_clk) disable iff (srst)
    (wr_fire && dp_idx == `IDX_CTRL && wd[`CTRL_INIT] && !init_busy
     && !line_idle && !idle_dis) |=> init_refused && !init_busy)
    else $error("init accepted while line busy");
  chk_init_forced: assert property (@(posedge ref_clk) disable iff (srst)
    (wr_fire && dp_idx == `IDX_CTRL && wd[`CTRL_INIT] && !init_busy
     && idle_dis) |=> init_busy && init_addr == `RST_PTR)
    else $error("init not started with idle check off");
  chk_recon_period: assert property (@(posedge ref_clk) disable iff (srst)
    (recon_cnt == recon_last && !reconfig_restart) |=> reconfig_timeout
    && recon_cnt == `RST_CNT) else $error("reconfig period wrong");
  chk_low_load: assert property (@(posedge ref_clk) disable iff (srst)
    (wr_fire && dp_idx == `IDX_PTR_LOW && !ap_read_data) |=>
    ptr == {$past(hi_bits), $past(wd)} && pf_pending)
    else $error("pointer load wrong");
  chk_data_read: assert property (@(posedge ref_clk) disable iff (srst)
    ap_read_data |=> hreadyout && hrdata[7:0] ==
    ($past(pf_capture) ? $past(ram_rdata) : $past(data_reg)))
    else $error("data read not served from prefetch");
  chk_autoinc_read: assert property (@(posedge ref_clk) disable iff (srst)
    (ap_read_data && autoinc && !wr_fire) |=> ptr == $past(ptr) + `PTR_STEP)
    else $error("read did not advance pointer");
  chk_write_nostall: assert property (@(posedge ref_clk) disable iff (srst)
    (fifo_in_valid && fifo_in_ready) |-> hreadyout ##1 fifo_out_valid)
    else $error("write stalled with queue space");
  chk_slow_arb: assert property (@(posedge ref_clk) disable iff (srst)
    (slow_arb && arb_tick && !wr_fire) |=> !arb_tick ##1 (arb_tick || !slow_arb))
    else $error("slow arbitration rate wrong");
  chk_ptr_readback: assert property (@(posedge ref_clk) disable iff (srst)
    (ap_take && !hwrite && ap_idx == `IDX_PTR_LOW) |=>
    hrdata[7:0] == $past(ptr[7:0])) else $error("pointer readback wrong");
endmodule // sequential_ram_access_port

`default_nettype wire

//--- verilog/ram_port_defs.svh
`ifndef RAM_PORT_DEFS_SVH
`define RAM_PORT_DEFS_SVH

// register indices; byte address is four times the index
`define IDX_PTR_HIGH    8'h02
`define IDX_PTR_LOW     8'h03
`define IDX_DATA        8'h04
`define IDX_FIRST_SETUP_REGISTER      8'h06
`define IDX_NET_TIMING  8'h07
`define IDX_CTRL        8'h08
`define IDX_STATUS      8'h09
`define IDX_MSB         9
`define IDX_LSB         2
`define HTRANS_ACTIVE   1

// field positions
`define PH_AUTOINC      7
`define PH_HI_MSB       2
`define SETUP_SLOW_ARB  0
`define NT_IDLE_DIS     2
`define NT_TMO_MSB      1
`define CTRL_INIT       0
`define ST_INIT_BUSY    0
`define ST_INIT_REFUSED 1

// buffer and fifo geometry
`define BUF_AW          11
`define BUF_DW          8
`define BUF_DEPTH       2048
`define BUF_LAST        11'h7FF
`define FIFO_DEPTH      16
`define FIFO_W          19
`define PTR_STEP        11'h001

// reset values
`define RST_PTR         11'h000
`define RST_BYTE        8'h00
`define RST_HI          3'h0
`define RST_TMO         2'h0
`define RST_BIT         1'b0
`define RST_WORD        32'h0000_0000
`define RST_CNT         23'h00_0000
`define RD_PAD          24'h00_0000

// timing: clock rate and reconfiguration periods in microseconds
`define CLK_MHZ         10
`define RECON_T0_US     420000
`define RECON_T1_US     105000
`define RECON_T2_US     52500
`define RECON_T3_US     26250
`define RECON_CW        23

`endif

//--- verilog/ram_port_pkg.sv
`default_nettype none
package ram_port_pkg;
  typedef enum logic {INIT_IDLE, INIT_CLEAR} init_state_t;
endpackage
`default_nettype wire

//--- verilog/buffer_units.sv
`timescale 1ns/1ns
`default_nettype none

// small fifo; depth must be a power of two
module sync_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             srst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) &&
                       (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = store[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule // sync_fifo

// single port byte store with registered read data
module byte_ram #(
  parameter int unsigned AW    = 11,
  parameter int unsigned DW    = 8,
  parameter int unsigned DEPTH = 2048
) (
  // clock
  input  wire logic          ref_clk,
  // access port
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic [DW-1:0]      rdata
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // byte_ram

`default_nettype wire

//--- testbench/host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ahb-lite master standing in for the host microcontroller
module host_model (
  // clock
  input  wire logic        ref_clk,
  // ahb-lite master side
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // one single word transfer; inputs only move at rising edges, so the
  // value seen at the falling edge is the one sampled at the next edge
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd);
    logic rdy;
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= {22'h00_0000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hwdata <= ~hwdata;
    do begin
      @(negedge ref_clk);
      rdy = hready;
      @(posedge ref_clk);
    end while (rdy !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    do begin
      @(negedge ref_clk);
      rdy = hready;
      rd  = hrdata;
      @(posedge ref_clk);
    end while (rdy !== 1'b1);
  endtask
endmodule // host_model

`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "ram_port_defs.svh"

module tb;
  localparam int RC0   = 40;
  localparam int RC1   = 20;
  localparam int RC2   = 10;
  localparam int RC3   = 5;
  localparam int LIMIT = 20000;

  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        line_idle = 1'b1;
  logic        reconfig_restart = 1'b0;
  logic        reconfig_timeout;
  logic        stalled = 1'b0;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          rc[4] = '{RC0, RC1, RC2, RC3};

  always #50 ref_clk = ~ref_clk;

  host_model host_model_inst (
    .ref_clk (ref_clk),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hsize   (hsize),
    .hwdata  (hwdata),
    .hready  (hreadyout),
    .hrdata  (hrdata)
  );

  sequential_ram_access_port #(
    .RECON_CYC_0 (RC0),
    .RECON_CYC_1 (RC1),
    .RECON_CYC_2 (RC2),
    .RECON_CYC_3 (RC3)
  ) sequential_ram_access_port_inst (
    .ref_clk          (ref_clk),
    .srst             (srst),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hreadyout),
    .hreadyout        (hreadyout),
    .hrdata           (hrdata),
    .hresp            (hresp),
    .line_idle        (line_idle),
    .reconfig_restart (reconfig_restart),
    .reconfig_timeout (reconfig_timeout)
  );

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (hreadyout === 1'b0)
      stalled <= 1'b1;
    if (cycles == LIMIT) begin
      errors++;
      $display("ERROR timeout expected %0d seen %0d", LIMIT, cycles);
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    host_model_inst.xfer(1'b1, idx, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp,
                        input string what);
    logic [31:0] r;
    host_model_inst.xfer(1'b0, idx, 8'h00, r);
    check(what, {24'h00_0000, exp}, r);
  endtask

  // high first, low commits; a settle gap before the first read
  task automatic load_ptr(input logic [7:0] hi, input logic [7:0] lo);
    wr(`IDX_PTR_HIGH, hi);
    wr(`IDX_PTR_LOW, lo);
    repeat (10) @(posedge ref_clk);
  endtask

  // measures the gap between two timeout pulses
  task automatic tmo_chk(input int sel);
    int n;
    wr(`IDX_NET_TIMING, 8'(sel));
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (reconfig_timeout !== 1'b1 && n < 200);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (reconfig_timeout !== 1'b1 && n < 200);
    check("timeout period", 32'(rc[sel]), 32'(n));
  endtask

  initial begin
    int i;
    int k;
    logic [31:0] r;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    check("hreadyout", 32'h0000_0001, {31'h0, hreadyout});
    check("hrdata", 32'h0000_0000, hrdata);
    check("hresp", 32'h0000_0000, {31'h0, hresp});
    rd_chk(`IDX_PTR_HIGH, 8'h00, "ptr_high");
    rd_chk(`IDX_PTR_LOW, 8'h00, "ptr_low");
    rd_chk(`IDX_FIRST_SETUP_REGISTER, 8'h00, "first_setup_register");
    rd_chk(`IDX_NET_TIMING, 8'h00, "net_timing");
    rd_chk(`IDX_STATUS, 8'h10, "status");
    wr(8'h05, 8'hA5);
    rd_chk(8'h05, 8'h00, "unmapped");
    // auto-increment writes across the top of the buffer
    wr(`IDX_PTR_HIGH, 8'h87);
    wr(`IDX_PTR_LOW, 8'hFE);
    for (i = 0; i < 4; i++)
      wr(`IDX_DATA, 8'hC0 + 8'(i));
    rd_chk(`IDX_PTR_LOW, 8'h02, "ptr_low after burst");
    rd_chk(`IDX_PTR_HIGH, 8'h80, "ptr_high after burst");
    // read back at normal then slow arbitration
    for (k = 0; k < 2; k++) begin
      wr(`IDX_FIRST_SETUP_REGISTER, 8'(k));
      load_ptr(8'h87, 8'hFE);
      for (i = 0; i < 4; i++)
        rd_chk(`IDX_DATA, 8'hC0 + 8'(i), "burst byte");
    end
    wr(`IDX_FIRST_SETUP_REGISTER, 8'h00);
    // without auto-increment the pointer holds
    load_ptr(8'h07, 8'hFF);
    rd_chk(`IDX_DATA, 8'hC1, "fixed byte");
    rd_chk(`IDX_DATA, 8'hC1, "fixed byte again");
    rd_chk(`IDX_PTR_LOW, 8'hFF, "fixed ptr_low");
    // init refused while the line is busy
    line_idle <= 1'b0;
    wr(`IDX_CTRL, 8'h01);
    rd_chk(`IDX_STATUS, 8'h02, "status refused");
    wr(`IDX_STATUS, 8'h02);
    rd_chk(`IDX_STATUS, 8'h00, "status cleared");
    wr(`IDX_NET_TIMING, 8'h04);
    wr(`IDX_CTRL, 8'h01);
    rd_chk(`IDX_STATUS, 8'h01, "status busy");
    // writes during the clear walk fill the queue and stall
    wr(`IDX_PTR_HIGH, 8'h80);
    wr(`IDX_PTR_LOW, 8'h10);
    for (i = 0; i < 20; i++)
      wr(`IDX_DATA, 8'h40 + 8'(i));
    check("stall seen", 32'h0000_0001, {31'h0, stalled});
    k = 0;
    do begin
      host_model_inst.xfer(1'b0, `IDX_STATUS, 8'h00, r);
      k++;
    end while (r[0] !== 1'b0 && k < 1000);
    check("init done", 32'h0000_0000, {31'h0, r[0]});
    wr(`IDX_NET_TIMING, 8'h00);
    line_idle <= 1'b1;
    load_ptr(8'h80, 8'h10);
    for (i = 0; i < 20; i++)
      rd_chk(`IDX_DATA, 8'h40 + 8'(i), "queued byte");
    load_ptr(8'h87, 8'hFE);
    rd_chk(`IDX_DATA, 8'h00, "cleared byte");
    // timeout periods; restart held keeps the timer from firing
    for (k = 0; k < 4; k++)
      tmo_chk(k);
    // restart goes up on an edge; the pulse launched at that edge is skipped
    @(posedge ref_clk);
    reconfig_restart <= 1'b1;
    @(posedge ref_clk);
    r = 32'h0000_0000;
    repeat (8) begin
      @(negedge ref_clk);
      if (reconfig_timeout !== 1'b0)
        r = 32'h0000_0001;
    end
    @(posedge ref_clk);
    reconfig_restart <= 1'b0;
    check("pulse under restart", 32'h0000_0000, r);
    wrap_up();
  end
endmodule // tb

`default_nettype wire
